/* File: snpmc_pkg.sv */
// Package with constants and types of the sensor node power-mode controller
`default_nettype none
package snpmc_pkg;
    // Register byte offsets
    localparam logic [7:0] SNPMC_CTRL_OFF = 8'h00;
    localparam logic [7:0] SNPMC_MODPWR_OFF = 8'h04;
    localparam logic [7:0] SNPMC_ALARM_OFF = 8'h08;
    localparam logic [7:0] SNPMC_STATUS_OFF = 8'h0C;
    localparam logic [7:0] SNPMC_ISTAT_OFF = 8'h10;
    localparam logic [7:0] SNPMC_ICLR_OFF = 8'h14;
    localparam logic [7:0] SNPMC_IEN_OFF = 8'h18;
    // Field positions and widths
    localparam int SNPMC_MODE_LSB = 0;
    localparam int SNPMC_WSEL_LSB = 4;
    localparam int SNPMC_NMOD = 4;
    localparam int SNPMC_NEVT = 5;
    localparam int SNPMC_ALARM_W = 22;
    // Mode request codes
    localparam logic [1:0] SNPMC_REQ_SLEEP = 2'h1;
    localparam logic [1:0] SNPMC_REQ_DEEP = 2'h2;
    localparam logic [1:0] SNPMC_REQ_HIB = 2'h3;
    // Reset values
    localparam logic [3:0] SNPMC_WSEL_RST = 4'h0;
    localparam logic [21:0] SNPMC_ALARM_RST = 22'h000001;
    // Alarm limits in seconds: 1 s to 31 days
    localparam logic [21:0] SNPMC_ALARM_MIN = 22'h000001;
    localparam logic [21:0] SNPMC_ALARM_MAX = 22'h28DE80;
    // Watchdog sleep intervals in ms, 16 ms to 8 s
    localparam logic [3:0] SNPMC_WSEL_MAX = 4'h9;
    localparam logic [13:0] SNPMC_WDT_MS [10] = '{14'h0010, 14'h0020, 14'h0040, 14'h0080, 14'h0100,
                                                 14'h01F4, 14'h03E8, 14'h07D0, 14'h0FA0, 14'h1F40};
    // Timing
    localparam int SNPMC_CLK_NS = 10;
    localparam int SNPMC_MS_NS = 1000000;
    localparam int SNPMC_MS_CYC = SNPMC_MS_NS / SNPMC_CLK_NS;
    localparam int SNPMC_CPURST_NS = 1000;
    localparam int SNPMC_CPURST_CYC = (SNPMC_CPURST_NS + SNPMC_CLK_NS - 1) / SNPMC_CLK_NS;
    localparam logic [9:0] SNPMC_SEC_MS = 10'h3E8;
    localparam logic [9:0] SNPMC_BLINK_MS = 10'h0FA;
    localparam logic [1:0] SNPMC_RESP_OK = 2'h0;
    localparam logic [1:0] SNPMC_RESP_ERR = 2'h2;
    // Operating states, one-hot
    typedef enum logic [3:0] {
        SNPMC_ON = 4'h1,
        SNPMC_SLEEP = 4'h2,
        SNPMC_DEEP = 4'h4,
        SNPMC_HIB = 4'h8
    } snpmc_state_t;
    // Wake and interrupt event vector
    typedef struct packed {
        logic hib_wake;
        logic rtc;
        logic wdt;
        logic accel;
        logic sensor;
    } snpmc_evt_t;
endpackage
`default_nettype wire

/* File: snpmc_ctrl.sv */
// Sensor node power-mode controller with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module snpmc_ctrl
    import snpmc_pkg::*;
#(
    parameter int MS_CYC = SNPMC_MS_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sensor_int,
    input wire logic accel_int,
    input wire logic hib_switch,
    output logic cpu_power_en,
    output logic cpu_halt,
    output logic cpu_reset_n,
    output logic [3:0] module_pwr_en,
    output logic led_red,
    output logic led_green,
    output logic irq
);
    snpmc_state_t state_reg, state_next;
    logic aw_full_reg, w_full_reg, wr_go;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, wmask;
    logic wstrb0_reg;
    logic [3:0] wsel_reg, wsel_wr;
    logic [3:0] modpwr_reg;
    logic [21:0] alarm_reg;
    snpmc_evt_t ist_reg, ien_reg, evt_set, evt_clr;
    logic [2:0] sens_sync_reg, acc_sync_reg, sw_sync_reg;
    logic sens_filt_reg, acc_filt_reg, sw_filt_reg;
    logic sens_ev, acc_ev, wdt_ev, rtc_ev, mode_wr, hib_refused_reg, hib_wake_reg;
    logic [1:0] mode_req;
    logic [31:0] ms_cnt_reg;
    logic ms_tick;
    logic [13:0] wdt_cnt_reg;
    logic [9:0] sub_ms_reg, blink_cnt_reg;
    logic [21:0] sec_cnt_reg;
    logic [7:0] rst_cnt_reg;
    logic first_run_reg;

    // Byte-lane mask from write strobes
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign mode_wr = wr_go && aw_addr_reg == SNPMC_CTRL_OFF && wstrb0_reg && mode_req != 2'h0;
    assign mode_req = w_data_reg[SNPMC_MODE_LSB +: 2];
    // Watchdog select being written, clamped; a sleep request in the same word uses it
    assign wsel_wr = (w_data_reg[SNPMC_WSEL_LSB +: 4] > SNPMC_WSEL_MAX)
                     ? SNPMC_WSEL_MAX : w_data_reg[SNPMC_WSEL_LSB +: 4];
    assign evt_clr = (wr_go && aw_addr_reg == SNPMC_ICLR_OFF) ? w_data_reg[SNPMC_NEVT-1:0] : '0;

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SNPMC_RESP_OK;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            wstrb0_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata & wmask;
                wstrb0_reg <= s_axi_wstrb[0]; // Master may drop strobes once W is taken
                w_full_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg > SNPMC_IEN_OFF || aw_addr_reg[1:0] != 2'h0
                                || aw_addr_reg == SNPMC_STATUS_OFF || aw_addr_reg == SNPMC_ISTAT_OFF)
                               ? SNPMC_RESP_ERR : SNPMC_RESP_OK;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= SNPMC_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= SNPMC_RESP_OK;
            unique case (s_axi_araddr)
                SNPMC_CTRL_OFF: s_axi_rdata <= {24'h000000, wsel_reg, 4'h0};
                SNPMC_MODPWR_OFF: s_axi_rdata <= {28'h0000000, modpwr_reg};
                SNPMC_ALARM_OFF: s_axi_rdata <= {10'h000, alarm_reg};
                SNPMC_STATUS_OFF: s_axi_rdata <= {23'h000000, led_green, led_red, hib_refused_reg,
                                                  sw_filt_reg, hib_wake_reg, state_reg};
                SNPMC_ISTAT_OFF: s_axi_rdata <= {27'h0000000, ist_reg};
                SNPMC_ICLR_OFF: s_axi_rdata <= 32'h00000000;
                SNPMC_IEN_OFF: s_axi_rdata <= {27'h0000000, ien_reg};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= SNPMC_RESP_ERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Software-written settings; module switches drop after hibernate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wsel_reg <= SNPMC_WSEL_RST;
            modpwr_reg <= 4'h0;
            alarm_reg <= SNPMC_ALARM_RST;
            ien_reg <= '0;
        end else if (state_reg == SNPMC_HIB) begin
            modpwr_reg <= 4'h0;
        end else if (wr_go) begin
            if (aw_addr_reg == SNPMC_CTRL_OFF && wstrb0_reg) begin
                wsel_reg <= wsel_wr;
            end
            if (aw_addr_reg == SNPMC_MODPWR_OFF && wstrb0_reg) begin
                modpwr_reg <= w_data_reg[SNPMC_NMOD-1:0];
            end
            if (aw_addr_reg == SNPMC_ALARM_OFF) begin
                alarm_reg <= (w_data_reg[SNPMC_ALARM_W-1:0] < SNPMC_ALARM_MIN) ? SNPMC_ALARM_MIN
                             : (w_data_reg[SNPMC_ALARM_W-1:0] > SNPMC_ALARM_MAX) ? SNPMC_ALARM_MAX
                             : w_data_reg[SNPMC_ALARM_W-1:0];
            end
            if (aw_addr_reg == SNPMC_IEN_OFF && wstrb0_reg) begin
                ien_reg <= w_data_reg[SNPMC_NEVT-1:0];
            end
        end
    end

    // Pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sens_sync_reg <= 3'h0;
            acc_sync_reg <= 3'h0;
            sw_sync_reg <= 3'h0;
            sens_filt_reg <= 1'b0;
            acc_filt_reg <= 1'b0;
            sw_filt_reg <= 1'b0;
        end else begin
            sens_sync_reg <= {sens_sync_reg[1:0], sensor_int};
            acc_sync_reg <= {acc_sync_reg[1:0], accel_int};
            sw_sync_reg <= {sw_sync_reg[1:0], hib_switch};
            if (sens_sync_reg[2] == sens_sync_reg[1]) sens_filt_reg <= sens_sync_reg[2];
            if (acc_sync_reg[2] == acc_sync_reg[1]) acc_filt_reg <= acc_sync_reg[2];
            if (sw_sync_reg[2] == sw_sync_reg[1]) sw_filt_reg <= sw_sync_reg[2];
        end
    end
    // Rising edges, masked in hibernate
    assign sens_ev = sens_sync_reg[2] == sens_sync_reg[1] && sens_sync_reg[2] && !sens_filt_reg
                     && state_reg != SNPMC_HIB;
    assign acc_ev = acc_sync_reg[2] == acc_sync_reg[1] && acc_sync_reg[2] && !acc_filt_reg
                    && state_reg != SNPMC_HIB;

    // Millisecond time base
    assign ms_tick = ms_cnt_reg == 32'(MS_CYC - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn || ms_tick) ms_cnt_reg <= 32'h00000000;
        else ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
    end

    // Watchdog interval, runs only in sleep
    assign wdt_ev = state_reg == SNPMC_SLEEP && ms_tick && wdt_cnt_reg == 14'h0001;
    always_ff @(posedge aclk) begin
        if (!aresetn) wdt_cnt_reg <= 14'h0000;
        else if (mode_wr && mode_req == SNPMC_REQ_SLEEP) wdt_cnt_reg <= SNPMC_WDT_MS[wsel_wr];
        else if (state_reg == SNPMC_SLEEP && ms_tick && wdt_cnt_reg != 14'h0000) wdt_cnt_reg <= wdt_cnt_reg - 14'h0001;
    end

    // Clock alarm in whole seconds, armed on deep sleep or hibernate entry
    assign rtc_ev = (state_reg == SNPMC_DEEP || state_reg == SNPMC_HIB) && ms_tick
                    && sub_ms_reg == SNPMC_SEC_MS - 10'h001 && sec_cnt_reg == 22'h000001;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sec_cnt_reg <= 22'h000000;
            sub_ms_reg <= 10'h000;
        end else if (state_reg == SNPMC_ON) begin
            sec_cnt_reg <= alarm_reg;
            sub_ms_reg <= 10'h000;
        end else if (ms_tick) begin
            sub_ms_reg <= (sub_ms_reg == SNPMC_SEC_MS - 10'h001) ? 10'h000 : sub_ms_reg + 10'h001;
            if (sub_ms_reg == SNPMC_SEC_MS - 10'h001 && sec_cnt_reg != 22'h000000) sec_cnt_reg <= sec_cnt_reg - 22'h000001;
        end
    end

    // State transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SNPMC_ON: begin
                if (mode_wr && mode_req == SNPMC_REQ_SLEEP) state_next = SNPMC_SLEEP;
                else if (mode_wr && mode_req == SNPMC_REQ_DEEP) state_next = SNPMC_DEEP;
                else if (mode_wr && mode_req == SNPMC_REQ_HIB && sw_filt_reg) state_next = SNPMC_HIB;
            end
            SNPMC_SLEEP: if (sens_ev || acc_ev || wdt_ev) state_next = SNPMC_ON;
            SNPMC_DEEP: if (sens_ev || acc_ev || rtc_ev) state_next = SNPMC_ON;
            SNPMC_HIB: if (rtc_ev) state_next = SNPMC_ON;
            default: state_next = SNPMC_ON;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) state_reg <= SNPMC_ON;
        else state_reg <= state_next;
    end

    // Hibernate flags: wake origin and refused entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hib_wake_reg <= 1'b0;
            hib_refused_reg <= 1'b0;
        end else begin
            if (state_reg == SNPMC_HIB && rtc_ev) hib_wake_reg <= 1'b1;
            else if (mode_wr) hib_wake_reg <= 1'b0;
            if (mode_wr) hib_refused_reg <= mode_req == SNPMC_REQ_HIB && !sw_filt_reg;
        end
    end

    // Sticky source flags, a set wins over a clear
    assign evt_set = '{hib_wake: state_reg == SNPMC_HIB && rtc_ev, rtc: rtc_ev, wdt: wdt_ev,
                       accel: acc_ev, sensor: sens_ev};
    always_ff @(posedge aclk) begin
        if (!aresetn) ist_reg <= '0;
        else ist_reg <= (ist_reg & ~evt_clr) | evt_set;
    end

    // Processor power, halt and reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_power_en <= 1'b1;
            cpu_halt <= 1'b0;
            cpu_reset_n <= 1'b0;
            rst_cnt_reg <= 8'(SNPMC_CPURST_CYC);
            module_pwr_en <= 4'h0;
            irq <= 1'b0;
        end else begin
            cpu_power_en <= state_next != SNPMC_HIB;
            cpu_halt <= state_next == SNPMC_SLEEP || state_next == SNPMC_DEEP;
            module_pwr_en <= (state_next == SNPMC_HIB) ? 4'h0 : modpwr_reg;
            irq <= |(ist_reg & ien_reg);
            if (state_reg == SNPMC_HIB) begin
                rst_cnt_reg <= 8'(SNPMC_CPURST_CYC);
                cpu_reset_n <= 1'b0;
            end else if (rst_cnt_reg != 8'h00) begin
                rst_cnt_reg <= rst_cnt_reg - 8'h01;
            end else begin
                cpu_reset_n <= 1'b1;
            end
        end
    end

    // Start-up indicators: red until switch enabled, then green blinks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_run_reg <= 1'b1;
            led_red <= 1'b0;
            led_green <= 1'b0;
            blink_cnt_reg <= 10'h000;
        end else begin
            if (sw_filt_reg) first_run_reg <= 1'b0;
            led_red <= first_run_reg && !sw_filt_reg;
            if (first_run_reg || state_reg != SNPMC_ON) begin
                led_green <= 1'b0;
                blink_cnt_reg <= 10'h000;
            end else if (ms_tick) begin
                blink_cnt_reg <= (blink_cnt_reg == SNPMC_BLINK_MS - 10'h001) ? 10'h000 : blink_cnt_reg + 10'h001;
                if (blink_cnt_reg == SNPMC_BLINK_MS - 10'h001) led_green <= !led_green;
            end
        end
    end

    // Checks
    sequence hib_exit_s;
        state_reg == SNPMC_HIB && rtc_ev;
    endsequence
    sequence reset_pulse_s;
        !cpu_reset_n [*8];
    endsequence
    chk_four_states: assert property (@(posedge aclk) disable iff (!aresetn) $onehot(state_reg))
        else $error("state not one-hot");
    chk_sleep_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == SNPMC_SLEEP && (wdt_ev || sens_ev) |=> state_reg == SNPMC_ON)
        else $error("sleep did not wake");
    chk_wdt_load: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_reg == SNPMC_SLEEP) |-> wdt_cnt_reg >= 14'h0010 && wdt_cnt_reg <= 14'h1F40)
        else $error("watchdog interval out of range");
    chk_retain_state: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(state_reg == SNPMC_DEEP || state_reg == SNPMC_SLEEP) |-> ##1 cpu_reset_n && !cpu_halt)
        else $error("resume reset the processor");
    chk_deep_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == SNPMC_DEEP && (rtc_ev || acc_ev) |=> state_reg == SNPMC_ON)
        else $error("deep sleep did not wake");
    chk_alarm_range: assert property (@(posedge aclk) disable iff (!aresetn)
        alarm_reg >= SNPMC_ALARM_MIN && alarm_reg <= SNPMC_ALARM_MAX)
        else $error("alarm out of range");
    chk_hib_power: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == SNPMC_HIB |-> !cpu_power_en && module_pwr_en == 4'h0)
        else $error("power kept in hibernate");
    chk_hib_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == SNPMC_HIB && !rtc_ev |=> state_reg == SNPMC_HIB)
        else $error("hibernate left without alarm");
    chk_hib_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        hib_exit_s |=> reset_pulse_s ##[1:120] cpu_reset_n)
        else $error("no processor reset after hibernate");
    chk_hib_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == SNPMC_ON && !sw_filt_reg |=> state_reg != SNPMC_HIB)
        else $error("hibernate without switch");
    chk_hib_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        hib_exit_s |=> hib_wake_reg && ist_reg.hib_wake)
        else $error("hibernate wake flag missing");
    chk_wake_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        wdt_ev |=> ist_reg.wdt)
        else $error("source flag not set");
endmodule
`default_nettype wire

/* File: snpmc_far_model.sv */
// Far-side model: sensor and accelerometer interrupt lines and hibernate switch
`timescale 1ns/1ns
`default_nettype none
module snpmc_far_model (
    input wire logic aclk,
    output logic sensor_int,
    output logic accel_int,
    output logic hib_switch
);
    // Idle lines and switch off at power-up
    initial begin
        sensor_int = 1'b0;
        accel_int = 1'b0;
        hib_switch = 1'b0;
    end
    // Pulse held long enough to cross the synchroniser
    task automatic pulse(input bit acc);
        @(posedge aclk);
        if (acc) begin
            accel_int <= 1'b1;
        end else begin
            sensor_int <= 1'b1;
        end
        repeat (6) @(posedge aclk);
        sensor_int <= 1'b0;
        accel_int <= 1'b0;
    endtask
    // Switch moved by hand, a plain level
    task automatic set_sw(input logic v);
        @(posedge aclk);
        hib_switch <= v;
    endtask
endmodule
`default_nettype wire

/* File: snpmc_ctrl_tb_top.sv */
// Testbench for the sensor node power-mode controller
`timescale 1ns/1ns
`default_nettype none
module snpmc_ctrl_tb_top;
    import snpmc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0] ws = 4'hF;
    // Writes that must be refused: read-only status places and an unaligned offset
    logic [7:0] dut_addr_bad [3] = '{8'h0C, 8'h10, 8'h02};
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    wire logic awr, wr, bv, arr, rv, sen, acc, hsw, pwr, halt, crst_n, red, grn, irq;
    wire logic [1:0] br, rr;
    wire logic [31:0] rdat;
    wire logic [3:0] mpw;
    int failures = 0;
    int total_checks = 0;
    int n;
    logic [1:0] resp;
    logic [31:0] data;
    logic g;
    // Clock at 100 MHz
    always #5 aclk = ~aclk;
    snpmc_ctrl #(.MS_CYC(10)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .sensor_int(sen), .accel_int(acc), .hib_switch(hsw), .cpu_power_en(pwr),
        .cpu_halt(halt), .cpu_reset_n(crst_n), .module_pwr_en(mpw), .led_red(red),
        .led_green(grn), .irq(irq));
    snpmc_far_model far_u (.aclk(aclk), .sensor_int(sen), .accel_int(acc), .hib_switch(hsw));
    // Shared comparison
    task automatic cmp(input string k, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s value %h expected %h", $time, k, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp("register", got, exp);
    endtask
    task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
        cmp("pin", got, exp);
    endtask
    // AXI4-Lite write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit ad, dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awr === 1'b1) begin
                ad = 1;
                awv <= 1'b0;
            end
            if (!dd && wr === 1'b1) begin
                dd = 1;
                wv <= 1'b0;
            end
        end
        do @(posedge aclk); while (bv !== 1'b1);
        resp = br;
        bre <= 1'b0;
    endtask
    // AXI4-Lite read
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge aclk);
        data = rdat;
        resp = rr;
        rre <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        axi_rd(a);
        cmp_reg(data & m, exp);
    endtask
    // Bounded wait for the processor to run again
    task automatic wait_wake(input int lim);
        n = 0;
        while (n < lim && (halt !== 1'b0 || pwr !== 1'b1)) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (60000) @(posedge aclk);
        failures++;
        stop_test();
    end
    // Test sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp_pin(crst_n, 0);
        cmp_pin(pwr, 1);
        repeat (105) @(posedge aclk);
        cmp_pin(crst_n, 1);
        cmp_pin(red, 1);
        rdc(SNPMC_STATUS_OFF, 32'h81, 32'h1FF);
        rdc(SNPMC_ALARM_OFF, 32'h1, '1);
        rdc(SNPMC_ISTAT_OFF, 0, '1);
        axi_rd(8'h1C);
        cmp_reg(data, 0);
        cmp_reg(resp, SNPMC_RESP_ERR);
        foreach (dut_addr_bad[i]) begin
            axi_wr(dut_addr_bad[i], 32'hF);
            cmp_reg(resp, SNPMC_RESP_ERR);
        end
        rdc(SNPMC_STATUS_OFF, 32'h81, 32'h1FF);
        tdone("reset and bus");
        axi_wr(SNPMC_CTRL_OFF, 32'(SNPMC_REQ_HIB));
        repeat (3) @(posedge aclk);
        cmp_pin(pwr, 1);
        rdc(SNPMC_STATUS_OFF, 32'h41, 32'h4F);
        axi_wr(SNPMC_IEN_OFF, 32'h1F);
        axi_wr(SNPMC_MODPWR_OFF, 0);
        axi_wr(SNPMC_CTRL_OFF, 32'(SNPMC_REQ_SLEEP));
        repeat (3) @(posedge aclk);
        cmp_pin(halt, 1);
        rdc(SNPMC_STATUS_OFF, 32'h2, 32'hF);
        wait_wake(400);
        cmp_pin(n > 120 && n < 400, 1);
        cmp_pin(crst_n, 1);
        rdc(SNPMC_ISTAT_OFF, 32'h4, '1);
        cmp_pin(irq, 1);
        axi_wr(SNPMC_ICLR_OFF, 32'h1F);
        rdc(SNPMC_ISTAT_OFF, 0, '1);
        cmp_pin(irq, 0);
        axi_wr(SNPMC_CTRL_OFF, 32'hF0);
        rdc(SNPMC_CTRL_OFF, 32'h90, '1);
        ws <= 4'hE;
        axi_wr(SNPMC_CTRL_OFF, 32'h51);
        ws <= 4'hF;
        rdc(SNPMC_CTRL_OFF, 32'h90, '1);
        rdc(SNPMC_STATUS_OFF, 32'h1, 32'hF);
        tdone("sleep watchdog");
        axi_wr(SNPMC_IEN_OFF, 32'h1E);
        axi_wr(SNPMC_CTRL_OFF, 32'h91);
        repeat (3) @(posedge aclk);
        cmp_pin(halt, 1);
        far_u.pulse(0);
        wait_wake(50);
        cmp_pin(n < 50, 1);
        cmp_pin(crst_n, 1);
        rdc(SNPMC_ISTAT_OFF, 32'h1, '1);
        cmp_pin(irq, 0);
        axi_wr(SNPMC_IEN_OFF, 32'h1F);
        repeat (2) @(posedge aclk);
        cmp_pin(irq, 1);
        axi_wr(SNPMC_ICLR_OFF, 32'h1F);
        axi_wr(SNPMC_CTRL_OFF, 32'(SNPMC_REQ_DEEP));
        repeat (400) @(posedge aclk);
        cmp_pin(halt, 1);
        far_u.pulse(1);
        wait_wake(50);
        cmp_pin(n < 50, 1);
        rdc(SNPMC_ISTAT_OFF, 32'h2, '1);
        axi_wr(SNPMC_ICLR_OFF, 32'h1F);
        tdone("sleep and deep sleep events");
        axi_wr(SNPMC_ALARM_OFF, 0);
        rdc(SNPMC_ALARM_OFF, 32'h1, '1);
        axi_wr(SNPMC_ALARM_OFF, 32'h3FFFFF);
        rdc(SNPMC_ALARM_OFF, 32'h28DE80, '1);
        axi_wr(SNPMC_ALARM_OFF, 32'h1);
        axi_wr(SNPMC_CTRL_OFF, 32'(SNPMC_REQ_DEEP));
        wait_wake(12000);
        cmp_pin(n > 9000 && n < 12000, 1);
        rdc(SNPMC_ISTAT_OFF, 32'h8, '1);
        axi_wr(SNPMC_ICLR_OFF, 32'h1F);
        tdone("deep sleep alarm");
        axi_wr(SNPMC_MODPWR_OFF, 32'hF);
        repeat (2) @(posedge aclk);
        cmp_pin(mpw, 4'hF);
        far_u.set_sw(1);
        repeat (10) @(posedge aclk);
        cmp_pin(red, 0);
        rdc(SNPMC_STATUS_OFF, 32'h20, 32'h20);
        g = grn;
        n = 0;
        while (n < 3000 && grn === g) begin
            @(posedge aclk);
            n++;
        end
        cmp_pin(n < 3000, 1);
        axi_wr(SNPMC_CTRL_OFF, 32'(SNPMC_REQ_HIB));
        repeat (3) @(posedge aclk);
        cmp_pin(pwr, 0);
        cmp_pin(mpw, 0);
        far_u.pulse(0);
        far_u.pulse(1);
        repeat (20) @(posedge aclk);
        cmp_pin(pwr, 0);
        wait_wake(12000);
        cmp_pin(n > 9000 && n < 12000, 1);
        cmp_pin(crst_n, 0);
        repeat (105) @(posedge aclk);
        cmp_pin(crst_n, 1);
        rdc(SNPMC_STATUS_OFF, 32'h11, 32'h1F);
        rdc(SNPMC_ISTAT_OFF, 32'h10, 32'h13);
        rdc(SNPMC_MODPWR_OFF, 0, '1);
        tdone("hibernate");
        stop_test();
    end
endmodule
`default_nettype wire
